// ### src/shu_pkg.sv
// Overview of operation
// RULE1 - Register left shift (ext 0x13): source shifted left by count low five bits, zero fill.
// RULE2 - Immediate left shift (ext 0x12): source shifted left by immediate count, zero fill.
// RULE3 - Register arithmetic right shift (ext 0x3b): sign bit replicated into vacated bits.
// RULE4 - Register arithmetic right shift ignores count bits above four; counts wrap modulo 32.
// RULE5 - Immediate arithmetic right shift (ext 0x3a): shift right by immediate, sign fill.
// RULE6 - Immediate count is five-bit unsigned, zero to thirty-one, never sign-extended.
// RULE7 - Field A selects the source register, field C the destination register.
// RULE8 - Word layout A 31-27, B 26-22, C 21-17, ext 16-11, imm 10-6, op 5-0; no exceptions.
package shu_pkg;
	localparam int DATA_W = 32;
	localparam int REG_W = 5;
	localparam int A_LSB = 27;
	localparam int B_LSB = 22;
	localparam int C_LSB = 17;
	localparam int EXT_LSB = 11;
	localparam int EXT_W = 6;
	localparam int IMM_LSB = 6;
	localparam int OP_LSB = 0;
	localparam int OP_W = 6;
	localparam logic [OP_W-1:0] OP_RTYPE = 6'h3a;
	localparam logic [EXT_W-1:0] EXT_SLL = 6'h13;
	localparam logic [EXT_W-1:0] EXT_SLLI = 6'h12;
	localparam logic [EXT_W-1:0] EXT_SRA = 6'h3b;
	localparam logic [EXT_W-1:0] EXT_SRAI = 6'h3a;
	localparam logic [DATA_W-1:0] RESULT_RST = 32'h0000_0000;
	localparam logic [REG_W-1:0] REG_RST = 5'h00;
endpackage : shu_pkg

// ### src/shu_barrel.sv
`timescale 1ns/10ps
module shu_barrel
	import shu_pkg::*;
(
	input wire logic [DATA_W-1:0] data_in, // Value to shift
	input wire logic [REG_W-1:0] amount, // Distance 0..31
	input wire logic dir_right, // High shifts right
	input wire logic fill_sign, // Right shifts copy sign bit
	output logic [DATA_W-1:0] data_out // Shifted value
);
	// ----------------------------------------
	// Five-stage log shifter
	// ----------------------------------------
	// Right shifts reuse one left shifter by reversing bits on both sides
	logic [DATA_W-1:0] stage [0:REG_W];
	logic [DATA_W-1:0] rev_in;
	logic fill;

	always_comb begin
		fill = dir_right & fill_sign & data_in[DATA_W-1];
	end

	genvar i;
	generate
		for (i = 0; i < DATA_W; i++) begin : g_rev
			assign rev_in[i] = dir_right ? data_in[DATA_W-1-i] : data_in[i];
			assign data_out[i] = dir_right ? stage[REG_W][DATA_W-1-i] : stage[REG_W][i];
		end
		for (i = 0; i < REG_W; i++) begin : g_stage
			assign stage[i+1] = amount[i] ?
				{stage[i][DATA_W-1-(2**i):0], {(2**i){fill}}} : stage[i]; // RULE1 RULE3
		end
	endgenerate

	assign stage[0] = rev_in;
endmodule : shu_barrel

// ### src/shu_shift_unit.sv
`timescale 1ns/10ps
module shu_shift_unit
	import shu_pkg::*;
(
	input wire logic clk, // 40 MHz core clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic instr_valid, // Instruction word valid this cycle
	input wire logic [DATA_W-1:0] instr, // R-type instruction word
	input wire logic [DATA_W-1:0] shift_source_data, // Value read from A register
	input wire logic [DATA_W-1:0] count_source_data, // Value read from B register
	output logic [REG_W-1:0] shift_source_reg, // A field register index
	output logic [REG_W-1:0] count_source_reg, // B field register index
	output logic [REG_W-1:0] result_dest_reg, // Destination index for write-back
	output logic [DATA_W-1:0] result, // Shift result
	output logic result_valid // One-cycle write-back strobe
);
	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic [OP_W-1:0] opcode;
	logic [EXT_W-1:0] ext;
	logic [REG_W-1:0] shift_count_field;
	logic is_sll, is_slli, is_sra, is_srai, is_shift;
	logic [REG_W-1:0] amount;
	logic dir_right;
	logic [DATA_W-1:0] shifted;

	always_comb begin
		opcode = instr[OP_LSB +: OP_W]; // RULE8
		ext = instr[EXT_LSB +: EXT_W]; // RULE8
		shift_count_field = instr[IMM_LSB +: REG_W]; // RULE6
		is_sll = (opcode == OP_RTYPE) && (ext == EXT_SLL); // RULE1
		is_slli = (opcode == OP_RTYPE) && (ext == EXT_SLLI); // RULE2
		is_sra = (opcode == OP_RTYPE) && (ext == EXT_SRA); // RULE3
		is_srai = (opcode == OP_RTYPE) && (ext == EXT_SRAI); // RULE5
		is_shift = instr_valid && (is_sll || is_slli || is_sra || is_srai);
		dir_right = is_sra || is_srai;
		// Only the low five count bits matter; the rest are dropped
		amount = (is_sll || is_sra) ? count_source_data[REG_W-1:0] // RULE4
			: shift_count_field; // RULE6
	end

	// Register indices go back to the register file combinationally
	assign shift_source_reg = instr[A_LSB +: REG_W]; // RULE7
	assign count_source_reg = instr[B_LSB +: REG_W];

	shu_barrel u_barrel (
		.data_in(shift_source_data),
		.amount(amount),
		.dir_right(dir_right),
		.fill_sign(1'b1), // RULE3 RULE5
		.data_out(shifted)
	);

	// ----------------------------------------
	// Result register
	// ----------------------------------------
	logic [DATA_W-1:0] next_result;
	logic [REG_W-1:0] next_result_dest_reg;
	logic next_result_valid;

	always_comb begin
		next_result = result;
		next_result_dest_reg = result_dest_reg;
		next_result_valid = 1'b0;
		if (is_shift) begin
			next_result = shifted; // RULE1 RULE2 RULE3 RULE5
			next_result_dest_reg = instr[C_LSB +: REG_W]; // RULE7
			next_result_valid = 1'b1; // RULE8
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			result <= RESULT_RST;
			result_dest_reg <= REG_RST;
			result_valid <= 1'b0;
		end else begin
			result <= next_result;
			result_dest_reg <= next_result_dest_reg;
			result_valid <= next_result_valid;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_sll;
		@(posedge clk) disable iff (sys_rst)
		(instr_valid && is_sll) |=> result_valid &&
			result == ($past(shift_source_data) << $past(count_source_data[REG_W-1:0]));
	endproperty
	a_sll: assert property (p_sll) else $error("sll result wrong"); // RULE1

	property p_slli;
		@(posedge clk) disable iff (sys_rst)
		(instr_valid && is_slli) |=> result ==
			($past(shift_source_data) << $past(instr[IMM_LSB +: REG_W]));
	endproperty
	a_slli: assert property (p_slli) else $error("slli result wrong"); // RULE2

	// Both sides signed, or the compare would turn the shift logical
	property p_sra;
		@(posedge clk) disable iff (sys_rst)
		(instr_valid && is_sra) |=> $signed(result) ==
			($signed($past(shift_source_data)) >>> $past(count_source_data[REG_W-1:0]));
	endproperty
	a_sra: assert property (p_sra) else $error("sra result wrong"); // RULE3

	property p_sra_wrap;
		@(posedge clk) disable iff (sys_rst)
		(instr_valid && is_sra && count_source_data[REG_W-1:0] == 5'h00) |=>
			result == $past(shift_source_data);
	endproperty
	a_sra_wrap: assert property (p_sra_wrap) else $error("sra count not wrapped"); // RULE4

	property p_srai;
		@(posedge clk) disable iff (sys_rst)
		(instr_valid && is_srai) |=> $signed(result) ==
			($signed($past(shift_source_data)) >>> $past(instr[IMM_LSB +: REG_W]));
	endproperty
	a_srai: assert property (p_srai) else $error("srai result wrong"); // RULE5

	property p_imm_unsigned;
		@(posedge clk) disable iff (sys_rst)
		(instr_valid && is_slli && instr[IMM_LSB +: REG_W] == 5'h1f) |=>
			result[DATA_W-2:0] == {(DATA_W-1){1'b0}};
	endproperty
	a_imm_unsigned: assert property (p_imm_unsigned) else $error("imm count signed"); // RULE6

	property p_dest;
		@(posedge clk) disable iff (sys_rst)
		is_shift |=> result_dest_reg == $past(instr[C_LSB +: REG_W]);
	endproperty
	a_dest: assert property (p_dest) else $error("destination index wrong"); // RULE7

	property p_valid;
		@(posedge clk) disable iff (sys_rst)
		result_valid |-> $past(is_shift);
	endproperty
	a_valid: assert property (p_valid) else $error("spurious write-back"); // RULE8

	// ----------------------------------------
	// Fill, wrap and hold checks
	// ----------------------------------------
	// Masks isolate the vacated bits, so a wrong fill shows apart from a wrong shift
	property p_sll_zero_fill;
		@(posedge clk) disable iff (sys_rst)
		(instr_valid && is_sll) |=>
			(result & ~(32'hffff_ffff << $past(count_source_data[REG_W-1:0])))
				== 32'h0000_0000;
	endproperty
	a_sll_zero_fill: assert property (p_sll_zero_fill) else $error("sll fill wrong"); // RULE1

	property p_sll_mod;
		@(posedge clk) disable iff (sys_rst)
		(instr_valid && is_sll) |=>
			result == ($past(shift_source_data) << ($past(count_source_data) % 32));
	endproperty
	a_sll_mod: assert property (p_sll_mod) else $error("sll count not mod 32"); // RULE1

	property p_slli_zero_fill;
		@(posedge clk) disable iff (sys_rst)
		(instr_valid && is_slli) |=>
			(result & ~(32'hffff_ffff << $past(instr[IMM_LSB +: REG_W])))
				== 32'h0000_0000;
	endproperty
	a_slli_zero_fill: assert property (p_slli_zero_fill) else $error("slli fill wrong"); // RULE2

	property p_sra_sign_fill;
		@(posedge clk) disable iff (sys_rst)
		(instr_valid && is_sra) |=>
			(result & ~(32'hffff_ffff >> $past(count_source_data[REG_W-1:0])))
				== ({DATA_W{$past(shift_source_data[DATA_W-1])}}
				& ~(32'hffff_ffff >> $past(count_source_data[REG_W-1:0])));
	endproperty
	a_sra_sign_fill: assert property (p_sra_sign_fill) else $error("sra fill wrong"); // RULE3

	property p_sra_positive;
		@(posedge clk) disable iff (sys_rst)
		(instr_valid && is_sra && !shift_source_data[DATA_W-1]) |=>
			result == ($past(shift_source_data) >> $past(count_source_data[REG_W-1:0]));
	endproperty
	a_sra_positive: assert property (p_sra_positive) else $error("sra positive wrong"); // RULE3

	// Upper count bits must not leak into the distance
	property p_sra_mod;
		@(posedge clk) disable iff (sys_rst)
		(instr_valid && is_sra) |=> $signed(result) ==
			($signed($past(shift_source_data)) >>> ($past(count_source_data) % 32));
	endproperty
	a_sra_mod: assert property (p_sra_mod) else $error("sra count not mod 32"); // RULE4

	property p_srai_sign_fill;
		@(posedge clk) disable iff (sys_rst)
		(instr_valid && is_srai) |=>
			(result & ~(32'hffff_ffff >> $past(instr[IMM_LSB +: REG_W])))
				== ({DATA_W{$past(shift_source_data[DATA_W-1])}}
				& ~(32'hffff_ffff >> $past(instr[IMM_LSB +: REG_W])));
	endproperty
	a_srai_sign_fill: assert property (p_srai_sign_fill) else $error("srai fill wrong"); // RULE5

	property p_srai_zero;
		@(posedge clk) disable iff (sys_rst)
		(instr_valid && is_srai && instr[IMM_LSB +: REG_W] == 5'h00) |=>
			result == $past(shift_source_data);
	endproperty
	a_srai_zero: assert property (p_srai_zero) else $error("srai zero wrong"); // RULE5

	// A sign-extended count would give a short shift here
	property p_imm_no_sign;
		@(posedge clk) disable iff (sys_rst)
		(instr_valid && is_srai && instr[IMM_LSB+REG_W-1]) |=>
			result[DATA_W-1:DATA_W/2-1] == {(DATA_W/2+1){$past(shift_source_data[DATA_W-1])}};
	endproperty
	a_imm_no_sign: assert property (p_imm_no_sign) else $error("imm count short"); // RULE6

	property p_take;
		@(posedge clk) disable iff (sys_rst)
		is_shift |=> result_valid;
	endproperty
	a_take: assert property (p_take) else $error("shift gave no write-back"); // RULE8

	// Refused words leave the last write-back untouched
	property p_hold;
		@(posedge clk) disable iff (sys_rst)
		!is_shift |=> !result_valid && $stable(result) && $stable(result_dest_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("refused word changed result"); // RULE8
endmodule : shu_shift_unit

// ### verification/shu_regfile_model.sv
`timescale 1ns/10ps
module shu_regfile_model
	import shu_pkg::*;
(
	input wire logic clk, // Core clock
	input wire logic [REG_W-1:0] rd_a, // Index of A
	input wire logic [REG_W-1:0] rd_b, // Index of B
	input wire logic wr_en, // Write-back strobe
	input wire logic [REG_W-1:0] wr_idx, // Write-back index
	input wire logic [DATA_W-1:0] wr_data, // Write-back value
	output logic [DATA_W-1:0] a_data, // Value of A
	output logic [DATA_W-1:0] b_data // Value of B
);
	// ----------
	// Read and write-back
	// ----------
	logic [DATA_W-1:0] regs [32];
	// Register zero always reads zero
	assign a_data = (rd_a == 5'h00) ? 32'h0 : regs[rd_a];
	assign b_data = (rd_b == 5'h00) ? 32'h0 : regs[rd_b];
	always @(posedge clk) begin
		if (wr_en) begin
			regs[wr_idx] <= wr_data;
		end
	end
endmodule : shu_regfile_model

// ### verification/shu_shift_unit_tb_top.sv
`timescale 1ns/10ps
module shu_shift_unit_tb_top;
	import shu_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic instr_valid = 1'b0;
	logic [DATA_W-1:0] instr = 32'h0;
	logic [DATA_W-1:0] a_data, b_data, result;
	logic [REG_W-1:0] a_idx, b_idx, c_idx;
	logic result_valid;
	int failures = 0;
	int total_checks = 0;
	int cycles = 0;
	always #12.5 clk = ~clk;
	shu_shift_unit dut (.clk(clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr(instr),
		.shift_source_data(a_data), .count_source_data(b_data), .shift_source_reg(a_idx),
		.count_source_reg(b_idx), .result_dest_reg(c_idx), .result(result),
		.result_valid(result_valid));
	shu_regfile_model rf (.clk(clk), .rd_a(a_idx), .rd_b(b_idx), .wr_en(result_valid),
		.wr_idx(c_idx), .wr_data(result), .a_data(a_data), .b_data(b_data));
	// ----------
	// Shared tasks
	// ----------
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic close_out;
		$display("checks=%0d failures=%0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out
	// Valid stays high between calls, so shifts go back to back
	task automatic run(input logic [5:0] ext, input logic [4:0] a, b, c, imm,
		input logic [DATA_W-1:0] exp);
		instr_valid = 1'b1;
		instr = {a, b, c, ext, imm, OP_RTYPE};
		@(posedge clk);
		#1;
		chk({31'h0, result_valid}, 32'h1);
		chk(result, exp);
		chk({27'h0, c_idx}, {27'h0, c});
	endtask : run
	task automatic idle(input string name);
		instr_valid = 1'b0;
		@(posedge clk);
		#1;
		chk({31'h0, result_valid}, 32'h0);
		$display("%s done", name);
	endtask : idle
	// ----------
	// Scenarios
	// ----------
	task automatic t_reg;
		run(EXT_SLL, 5'h07, 5'h08, 5'h01, 5'h00, 32'h0000_0010);
		run(EXT_SRA, 5'h07, 5'h08, 5'h02, 5'h00, 32'hf800_0000);
		run(EXT_SRA, 5'h09, 5'h0a, 5'h03, 5'h00, 32'h0000_0000);
		run(EXT_SRA, 5'h07, 5'h0e, 5'h0f, 5'h00, 32'h8000_0001);
		run(EXT_SLL, 5'h07, 5'h0a, 5'h04, 5'h00, 32'h8000_0000);
		idle("t_reg");
	endtask : t_reg
	task automatic t_imm;
		run(EXT_SLLI, 5'h09, 5'h00, 5'h05, 5'h01, 32'hffff_ffe0);
		run(EXT_SLLI, 5'h07, 5'h00, 5'h10, 5'h1f, 32'h8000_0000);
		run(EXT_SRAI, 5'h07, 5'h00, 5'h06, 5'h1f, 32'hffff_ffff);
		run(EXT_SRAI, 5'h09, 5'h00, 5'h0b, 5'h04, 32'h07ff_ffff);
		run(EXT_SRAI, 5'h07, 5'h00, 5'h0c, 5'h00, 32'h8000_0001);
		idle("t_imm");
	endtask : t_imm
	task automatic t_refuse;
		instr_valid = 1'b1;
		instr = {5'h07, 5'h08, 5'h0d, 6'h03, 5'h00, OP_RTYPE};
		@(posedge clk);
		#1;
		instr = {5'h07, 5'h08, 5'h0d, EXT_SLL, 5'h00, 6'h3b};
		chk({31'h0, result_valid}, 32'h0);
		@(posedge clk);
		#1;
		chk({31'h0, result_valid}, 32'h0);
		chk(result, 32'h8000_0001);
		idle("t_refuse");
	endtask : t_refuse
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			failures++;
			close_out();
		end
	end
	initial begin
		rf.regs[7] = 32'h8000_0001;
		rf.regs[8] = 32'h0000_0024;
		rf.regs[9] = 32'h7fff_fff0;
		rf.regs[10] = 32'h0000_001f;
		rf.regs[14] = 32'h0000_0060;
		repeat (8) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		chk(result, RESULT_RST);
		chk({31'h0, result_valid}, 32'h0);
		chk({27'h0, c_idx}, {27'h0, REG_RST});
		t_reg();
		t_imm();
		t_refuse();
		close_out();
	end
endmodule : shu_shift_unit_tb_top
